// ---- core/run_reset_control.sv ----
// run/stop and soft reset command control of the host controller
`timescale 1ns/100ps
module run_reset_control
  import run_reset_pkg::*;
#(
  parameter int STOP_LIMIT = STOP_LIMIT_CYCLES,
  parameter int HOLD = RESET_HOLD_CYCLES
)
(
  input wire logic ref_clk,
  input wire logic resetn,
  input cmd_write_s cmd_write,
  input wire logic error_stop,
  input wire logic pipe_busy,
  output cmd_status_s status,
  output logic sched_execute,
  output logic txn_abort,
  output logic ctrl_reset,
  output logic port_owner_companion,
  output logic port_bus_reset
);
  typedef enum logic [2:0]
  {
    ST_HALTED = 3'b001,
    ST_RUNNING = 3'b010,
    ST_STOPPING = 3'b100
  } run_state_e;

  localparam int SW = $clog2(STOP_LIMIT + 1);

  logic rst_sync1_reg;
  logic rst_sync2_reg;
  logic rst_n;
  logic run_reg;
  logic reset_bit_reg;
  logic halted_reg;
  logic port_comp_reg;
  logic [SW-1:0] stop_cnt_reg;
  run_state_e state_reg;
  run_state_e state_next;
  logic seq_busy;
  logic seq_done;
  logic reset_start;

  initial
  begin
    if (STOP_LIMIT < 2)
      $error("stop limit must be at least two cycles");
    if (HOLD < 8 || HOLD > 32)
      $error("reset hold must lie between 8 and 32 cycles");
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_sync1_reg <= 1'b0;
      rst_sync2_reg <= 1'b0;
    end
    else
    begin
      rst_sync1_reg <= 1'b1;
      rst_sync2_reg <= rst_sync1_reg;
    end
  end
  assign rst_n = rst_sync2_reg;

  assign reset_start = cmd_write.wr && cmd_write.data[CMD_RESET_BIT] && !reset_bit_reg;

  reset_sequencer #(.HOLD(HOLD)) u_seq
  (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .start(reset_start),
    .busy(seq_busy),
    .done(seq_done)
  );

  // reset bit: set by write of one, cleared only by completion
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      reset_bit_reg <= CMD_RESET_RESET_VAL;
    else if (reset_start)
      reset_bit_reg <= 1'b1;
    else if (seq_done)
      reset_bit_reg <= 1'b0;
  end

  // run bit; reset forces it clear and writes during reset are dropped
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      run_reg <= CMD_RUN_RESET_VAL;
    else if (reset_start || reset_bit_reg)
      run_reg <= 1'b0;
    else if (error_stop)
      run_reg <= 1'b0;
    else if (cmd_write.wr)
      run_reg <= cmd_write.data[CMD_RUN_BIT];
  end

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_HALTED:
        if (run_reg)
          state_next = ST_RUNNING;
      ST_RUNNING:
        if (!run_reg)
          state_next = ST_STOPPING;
      ST_STOPPING:
        if (!pipe_busy || stop_cnt_reg == SW'(1))
          state_next = ST_HALTED;
      default:
        state_next = ST_HALTED;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      state_reg <= ST_HALTED;
    else if (reset_bit_reg)
      state_reg <= ST_HALTED;
    else
      state_reg <= state_next;
  end

  // bounds the drain of pipelined work to the stop limit
  // one cycle goes to entering the stopping state, so the count starts one short
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      stop_cnt_reg <= '0;
    else if (reset_bit_reg || state_reg != ST_STOPPING)
      stop_cnt_reg <= SW'(STOP_LIMIT - 1);
    else if (stop_cnt_reg != '0)
      stop_cnt_reg <= stop_cnt_reg - SW'(1);
  end

  // halted only once stopped; cleared as soon as run goes high
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      halted_reg <= HALTED_RESET_VAL;
    else if (run_reg)
      halted_reg <= 1'b0;
    else if (state_next == ST_HALTED)
      halted_reg <= 1'b1;
  end

  // ports go back to the companion on every controller reset
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      port_comp_reg <= 1'b1;
    else if (reset_bit_reg)
      port_comp_reg <= 1'b1;
    else if (run_reg)
      port_comp_reg <= 1'b0;
  end

  assign status.run_enable = run_reg;
  assign status.soft_reset = reset_bit_reg;
  assign status.halted = halted_reg && !run_reg;
  // no new schedule work while draining after a stop
  assign sched_execute = (state_reg == ST_RUNNING) && !reset_bit_reg;
  assign txn_abort = reset_bit_reg;
  assign ctrl_reset = reset_bit_reg || seq_busy;
  assign port_owner_companion = port_comp_reg;
  // controller reset is kept away from port signalling
  assign port_bus_reset = 1'b0;

  sequence s_reset_req;
    reset_start;
  endsequence

  sequence s_reset_done;
    !reset_bit_reg && !run_reg;
  endsequence

  chk_reset_self_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_reset_req |=> reset_bit_reg [*1] ##[1:40] s_reset_done)
    else $error("reset bit did not self clear");

  chk_reset_held: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(reset_bit_reg) |-> reset_bit_reg [*8])
    else $error("reset bit dropped early");

  chk_abort_now: assert property (@(posedge ref_clk) disable iff (!rst_n)
    reset_bit_reg |-> txn_abort && !sched_execute)
    else $error("transaction not aborted during reset");

  chk_no_port_reset: assert property (@(posedge ref_clk) disable iff (!rst_n)
    reset_bit_reg |-> !port_bus_reset)
    else $error("bus reset driven by controller reset");

  chk_ports_released: assert property (@(posedge ref_clk) disable iff (!rst_n)
    reset_bit_reg |=> port_owner_companion)
    else $error("port ownership not returned");

  chk_halt_zero_run: assert property (@(posedge ref_clk) disable iff (!rst_n)
    run_reg |-> !status.halted)
    else $error("halted while run set");

  chk_run_executes: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(run_reg) && !reset_bit_reg |=> sched_execute)
    else $error("schedule not executing with run set");

  chk_halt_after_stop: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(status.halted) |-> state_reg == ST_HALTED)
    else $error("halted raised before stop");

  chk_reset_clears_fsm: assert property (@(posedge ref_clk) disable iff (!rst_n)
    reset_bit_reg |=> state_reg == ST_HALTED && !run_reg)
    else $error("state not reset");

  chk_stop_bound: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state_reg == ST_STOPPING |-> stop_cnt_reg != '0)
    else $error("stop limit exceeded");
endmodule

// ---- inc/run_reset_pkg.sv ----
// constants and carriers for the run and reset command control
// Contract
// - a one written to the reset bit returns pipelines, timers, counters and state machines to initial values.
// - a controller reset aborts at once any bus transaction in progress.
// - a controller reset never drives a bus reset on a downstream port.
// - a controller reset restores all operational and port state and hands ports to the companion.
// - the device clears the reset bit itself when the reset process ends.
// - a written zero to the reset bit during a reset is ignored and the reset runs to completion.
// - while the run bit is one the schedule keeps executing, and zero asks for a stop.
// - after run is cleared the device finishes pending work and halts within 16 micro-frames.
// - the halted flag rises only after pending transactions finish and the stopped state is entered (the code also raises it at the stop limit with pipe_busy high).
// - the halted flag is zero whenever run is one and is set once stopped, by software or error.
package run_reset_pkg;
  localparam int CMD_RUN_BIT = 0;
  localparam int CMD_RESET_BIT = 1;
  localparam logic CMD_RUN_RESET_VAL = 1'b0;
  localparam logic CMD_RESET_RESET_VAL = 1'b0;
  localparam logic HALTED_RESET_VAL = 1'b1;
  localparam int CLK_MHZ = 200;
  localparam int MICROFRAME_US = 125;
  localparam int STOP_LIMIT_UFRAMES = 16;
  localparam int UFRAME_CYCLES = MICROFRAME_US * CLK_MHZ;
  localparam int STOP_LIMIT_CYCLES = STOP_LIMIT_UFRAMES * UFRAME_CYCLES;
  localparam int RESET_HOLD_CYCLES = 16;

  typedef struct packed {
    logic wr;
    logic [1:0] data;
  } cmd_write_s;

  typedef struct packed {
    logic run_enable;
    logic soft_reset;
    logic halted;
  } cmd_status_s;
endpackage

// ---- core/reset_sequencer.sv ----
// counted sequencer that holds the internal reset for a fixed span
`timescale 1ns/100ps
module reset_sequencer
  import run_reset_pkg::*;
#(
  parameter int HOLD = RESET_HOLD_CYCLES
)
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic start,
  output logic busy,
  output logic done
);
  localparam int CW = $clog2(HOLD + 1);
  logic [CW-1:0] cnt_reg;

  initial
  begin
    if (HOLD < 1)
      $error("reset hold must be at least one cycle");
  end

  // a fresh start while busy is ignored: the sequence always finishes
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_reg <= '0;
    else if (cnt_reg != '0)
      cnt_reg <= cnt_reg - CW'(1);
    else if (start)
      cnt_reg <= CW'(HOLD);
  end

  assign busy = (cnt_reg != '0);
  assign done = (cnt_reg == CW'(1));
endmodule

// ---- bench/downstream_traffic_model.sv ----
// downstream traffic model: transactions stay outstanding after a stop
`timescale 1ns/100ps
module downstream_traffic_model
(
  input wire logic ref_clk,
  input wire logic sched_execute,
  input wire logic txn_abort,
  input wire logic endless,
  input wire logic [7:0] tail_len,
  output logic pipe_busy
);
  logic [7:0] left_reg;
  initial left_reg = 8'h00;
  // endless tail models a stuck device: the stop limit ends the stop wait, and only txn_abort clears the tail
  always_ff @(posedge ref_clk)
  begin
    if (txn_abort)
      left_reg <= 8'h00;
    else if (sched_execute)
      left_reg <= tail_len;
    else if (left_reg != 8'h00 && !endless)
      left_reg <= left_reg - 8'h01;
  end
  assign pipe_busy = (left_reg != 8'h00);
endmodule

// ---- bench/tb_run_reset_control.sv ----
// self-checking bench for the run and reset command control
`timescale 1ns/100ps
`define CHK(nm, e, g) if ((g) !== (e)) begin $display("MISMATCH %s exp %0h got %0h", nm, e, g); mismatches++; end n_tests++;
module tb_run_reset_control;
  import run_reset_pkg::*;
  localparam int STOP_LIM = 50;
  localparam int HOLD_N = 8;
  logic ref_clk, resetn, error_stop, endless, pipe_busy, sched_execute;
  logic txn_abort, ctrl_reset, owner, bus_rst;
  logic [7:0] tail_len;
  cmd_write_s cmd_write;
  cmd_status_s status;
  int mismatches, n_tests, cycles, hi_cnt, n;
  run_reset_control #(.STOP_LIMIT(STOP_LIM), .HOLD(HOLD_N)) dut (.ref_clk(ref_clk),
    .resetn(resetn), .cmd_write(cmd_write), .error_stop(error_stop), .pipe_busy(pipe_busy),
    .status(status), .sched_execute(sched_execute), .txn_abort(txn_abort),
    .ctrl_reset(ctrl_reset), .port_owner_companion(owner), .port_bus_reset(bus_rst));
  downstream_traffic_model far (.ref_clk(ref_clk), .sched_execute(sched_execute),
    .txn_abort(txn_abort), .endless(endless), .tail_len(tail_len), .pipe_busy(pipe_busy));
  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  task automatic summarize();
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // hang guard, far above the longest stop wait
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      mismatches++;
      summarize();
    end
  end
  always @(negedge ref_clk)
  begin
    if (status.soft_reset === 1'b1)
      hi_cnt++;
    `CHK("port_bus_reset", 1'b0, bus_rst)
  end
  task automatic wr(input logic [1:0] d);
    @(posedge ref_clk);
    cmd_write <= '{1'b1, d};
    @(posedge ref_clk);
    cmd_write <= '{1'b0, 2'h0};
    #1;
  endtask
  task automatic wait_halt();
    n = 0;
    while (status.halted !== 1'b1 && n < 200)
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
  endtask
  task automatic t_run_stop();
    tail_len <= 8'h05;
    wr(2'h1);
    `CHK("run", 1'b1, status.run_enable)
    `CHK("halted_run", 1'b0, status.halted)
    @(posedge ref_clk);
    #1;
    `CHK("execute", 1'b1, sched_execute)
    wr(2'h0);
    `CHK("halted_tail", 1'b0, status.halted)
    wait_halt();
    `CHK("halted", 1'b1, status.halted)
    `CHK("busy_done", 1'b0, pipe_busy)
  endtask
  task automatic t_stall_stop();
    endless <= 1'b1;
    wr(2'h1);
    wr(2'h0);
    wait_halt();
    `CHK("stall_halt", 1'b1, status.halted)
    `CHK("stall_wait", 1'b1, (n > STOP_LIM - 5) && (n <= STOP_LIM))
  endtask
  task automatic t_soft_reset();
    hi_cnt = 0;
    wr(2'h2);
    `CHK("rst_bit", 1'b1, status.soft_reset)
    `CHK("abort", 1'b1, txn_abort)
    `CHK("ctrl_reset", 1'b1, ctrl_reset)
    wr(2'h0);
    `CHK("rst_kept", 1'b1, status.soft_reset)
    `CHK("owner", 1'b1, owner)
    wr(2'h1);
    n = 0;
    while (status.soft_reset === 1'b1 && n < 40)
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    #3;
    `CHK("rst_len", HOLD_N, hi_cnt)
    `CHK("run_after", 1'b0, status.run_enable)
    `CHK("halt_after", 1'b1, status.halted)
    `CHK("tail_gone", 1'b0, pipe_busy)
  endtask
  task automatic t_error_stop();
    endless <= 1'b0;
    tail_len <= 8'h03;
    wr(2'h1);
    @(posedge ref_clk);
    error_stop <= 1'b1;
    @(posedge ref_clk);
    error_stop <= 1'b0;
    @(posedge ref_clk);
    #1;
    `CHK("err_run", 1'b0, status.run_enable)
    wait_halt();
    `CHK("err_halt", 1'b1, status.halted)
  endtask
  initial
  begin
    resetn = 1'b0;
    cmd_write = '{1'b0, 2'h0};
    error_stop = 1'b0;
    endless = 1'b0;
    tail_len = 8'h00;
    mismatches = 0;
    n_tests = 0;
    cycles = 0;
    hi_cnt = 0;
    repeat (20) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
    `CHK("rv_run", CMD_RUN_RESET_VAL, status.run_enable)
    `CHK("rv_halt", HALTED_RESET_VAL, status.halted)
    `CHK("rv_owner", 1'b1, owner)
    t_run_stop();
    t_stall_stop();
    t_soft_reset();
    t_error_stop();
    summarize();
  end
endmodule
